// >>> verilog/ipf_cfg.svh
// Purpose: Constants for the interrupt priority field block
// Assumes: Word index times four gives the byte address
// Notes:   Definitions only
`ifndef IPF_CFG_SVH
`define IPF_CFG_SVH

// Register word indices
`define IPF_IDX_PRIO7    8'h07
`define IPF_IDX_PRIO8    8'h08
`define IPF_IDX_PRIO9    8'h09
`define IPF_IDX_REQSTAT  8'h20

// Register geometry
`define IPF_REG_W        16
`define IPF_FIELD_W      2
`define IPF_FIELDS_REG   8
`define IPF_N_REGS       3
`define IPF_N_SRC        24

// Reset values and writable masks
`define IPF_PRIO_RESET   16'h0000
`define IPF_WMASK7       16'hFFFF
`define IPF_WMASK8       16'hF3FF
`define IPF_WMASK9       16'hFFFF

// Field encodings
`define IPF_FIELD_OFF    2'h0
`define IPF_LEVEL_NONE   2'h0

`endif

// >>> verilog/ipf_pkg.sv
// Purpose: Types shared by the priority field block
// Assumes: ipf_cfg.svh supplies all figures
// Notes:   No constants of its own beyond the types
`include "ipf_cfg.svh"

package ipf_pkg;

    // APB answer sequencing
    typedef enum logic [0:0] {
        IPF_ST_IDLE,
        IPF_ST_ANSWER
    } ipf_apb_st_t;

    // Register selected by an address
    typedef enum logic [2:0] {
        IPF_SEL_NONE,
        IPF_SEL_PRIO7,
        IPF_SEL_PRIO8,
        IPF_SEL_PRIO9,
        IPF_SEL_REQSTAT
    } ipf_sel_t;

    // Register side state
    typedef struct packed {
        ipf_apb_st_t            st;
        logic [`IPF_REG_W-1:0]  prio7;
        logic [`IPF_REG_W-1:0]  prio8;
        logic [`IPF_REG_W-1:0]  prio9;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } ipf_regs_t;

endpackage : ipf_pkg

// >>> verilog/ipf_lvl_if.sv
// Purpose: Carries level fields to the gate and its results back
// Assumes: Single clock domain
// Notes:   Field k sits at bits 2k+1:2k
`timescale 1ns/100ps
`include "ipf_cfg.svh"

interface ipf_lvl_if #(
    parameter int N_SRC = `IPF_N_SRC
);
    logic [2*N_SRC-1:0] fields;
    logic [N_SRC-1:0]   req;
    logic [2*N_SRC-1:0] level;

    modport owner (output fields, input req, input level);
    modport gate  (input fields, output req, output level);
endinterface : ipf_lvl_if

// >>> verilog/ipf_gate.sv
// Purpose: Gates source requests by field and maps field to level
// Assumes: Source requests come from logic on pclk
// Notes:   Results are registered, one cycle behind fields
`timescale 1ns/100ps
`include "ipf_cfg.svh"

module ipf_gate #(
    parameter int N_SRC = `IPF_N_SRC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic [N_SRC-1:0]  src_request,
    ipf_lvl_if.gate                lvl
);

    typedef struct packed {
        logic [N_SRC-1:0]   req;
        logic [2*N_SRC-1:0] level;
    } ipf_gate_st_t;

    ipf_gate_st_t       s_q;
    ipf_gate_st_t       s_d;
    logic [N_SRC-1:0]   req_w;
    logic [2*N_SRC-1:0] level_w;

    // Per source decode
    for (genvar k = 0; k < N_SRC; k++) begin : g_src
        logic [1:0] f;
        logic       en;
        assign f  = lvl.fields[2*k +: 2];
        assign en = (f != `IPF_FIELD_OFF);
        assign req_w[k] = en & src_request[k];
        assign level_w[2*k +: 2] = en ? 2'(f - 2'h1) : `IPF_LEVEL_NONE;
    end

    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.req   = req_w;
        s_d.level = level_w;
    end

    // Frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign lvl.req   = s_q.req;
    assign lvl.level = s_q.level;

endmodule : ipf_gate

// >>> verilog/ipf_prio_fields.sv
// Purpose: APB register file of 2-bit interrupt level fields
// Assumes: APB3 slave, 32-bit data, priority registers in the low 16 bits, request status in the low 24
// Notes:   Source k is register (k/8), bit pair (k%8); source 13 unused
//
// Operation
// - Field 1..3 gives level 0..2
// - Field zero disables the source
// - No source above level two
// - Every field resets to disabled
// - Reserved bits read zero, ignore writes
// - Seventh register low fields: timers B0, C3-C1
// - Eighth register: serial0 fields, 11-10 reserved
// - Eighth register low fields: timers A3-A1
// - Ninth register 15-12: PWM fault levels
// - Ninth register 11-8: PWM reload levels
// - Ninth register 7-4: converter zero-cross levels
// - Ninth register 3-0: converter complete levels
// - Seventh register high fields: timers A0, B3-B1
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "ipf_cfg.svh"

module ipf_prio_fields #(
    parameter int ADDR_W = 12,
    parameter int N_SRC  = `IPF_N_SRC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [N_SRC-1:0]  src_request,
    output logic [N_SRC-1:0]       arb_request,
    output logic [2*N_SRC-1:0]     arb_level
);

    ipf_pkg::ipf_regs_t r_q;
    ipf_pkg::ipf_regs_t r_d;
    ipf_pkg::ipf_sel_t  sel;
    logic               access;
    logic [15:0]        wr_val;

    ipf_lvl_if #(.N_SRC(N_SRC)) lvl ();

    // Address to register; misaligned counts as unmapped
    function automatic ipf_pkg::ipf_sel_t ipf_decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2];
        ipf_decode = ipf_pkg::IPF_SEL_NONE;
        if (a[1:0] == 2'h0) begin
            if (w == (ADDR_W-2)'(`IPF_IDX_PRIO7)) begin
                ipf_decode = ipf_pkg::IPF_SEL_PRIO7;
            end else if (w == (ADDR_W-2)'(`IPF_IDX_PRIO8)) begin
                ipf_decode = ipf_pkg::IPF_SEL_PRIO8;
            end else if (w == (ADDR_W-2)'(`IPF_IDX_PRIO9)) begin
                ipf_decode = ipf_pkg::IPF_SEL_PRIO9;
            end else if (w == (ADDR_W-2)'(`IPF_IDX_REQSTAT)) begin
                ipf_decode = ipf_pkg::IPF_SEL_REQSTAT;
            end
        end
    endfunction : ipf_decode

    assign sel    = ipf_decode(paddr);
    assign access = psel & penable;
    assign wr_val = pwdata[15:0];

    // Bus sequencing and register update
    always_comb begin
        r_d = r_q;
        case (r_q.st)
            ipf_pkg::IPF_ST_IDLE: begin
                r_d.pready  = 1'b0;
                r_d.pslverr = 1'b0;
                if (access) begin
                    // Registered read data costs one wait state
                    r_d.st      = ipf_pkg::IPF_ST_ANSWER;
                    r_d.pready  = 1'b1;
                    r_d.pslverr = (sel == ipf_pkg::IPF_SEL_NONE);
                    r_d.prdata  = 32'h0000_0000;
                    case (sel)
                        ipf_pkg::IPF_SEL_PRIO7: r_d.prdata[15:0] = r_q.prio7;
                        ipf_pkg::IPF_SEL_PRIO8: r_d.prdata[15:0] = r_q.prio8;
                        ipf_pkg::IPF_SEL_PRIO9: r_d.prdata[15:0] = r_q.prio9;
                        ipf_pkg::IPF_SEL_REQSTAT: r_d.prdata[N_SRC-1:0] = lvl.req;
                        default: r_d.prdata = 32'h0000_0000;
                    endcase
                end
            end
            ipf_pkg::IPF_ST_ANSWER: begin
                // Write commits on the edge that sees pready
                if (access && pwrite) begin
                    case (sel)
                        ipf_pkg::IPF_SEL_PRIO7: r_d.prio7 = wr_val & `IPF_WMASK7;
                        ipf_pkg::IPF_SEL_PRIO8: r_d.prio8 = wr_val & `IPF_WMASK8;
                        ipf_pkg::IPF_SEL_PRIO9: r_d.prio9 = wr_val & `IPF_WMASK9;
                        default: r_d.prio9 = r_q.prio9;
                    endcase
                end
                r_d.st      = ipf_pkg::IPF_ST_IDLE;
                r_d.pready  = 1'b0;
                r_d.pslverr = 1'b0;
            end
            default: begin
                r_d.st     = ipf_pkg::IPF_ST_IDLE;
                r_d.pready = 1'b0;
            end
        endcase
    end

    // State register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q.st      <= ipf_pkg::IPF_ST_IDLE;
            r_q.prio7   <= `IPF_PRIO_RESET;
            r_q.prio8   <= `IPF_PRIO_RESET;
            r_q.prio9   <= `IPF_PRIO_RESET;
            r_q.prdata  <= 32'h0000_0000;
            r_q.pready  <= 1'b0;
            r_q.pslverr <= 1'b0;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    // Field k at bits 2k+1:2k, registers stacked low to high
    assign lvl.fields = {r_q.prio9, r_q.prio8, r_q.prio7};

    ipf_gate #(.N_SRC(N_SRC)) u_gate (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .src_request (src_request),
        .lvl         (lvl)
    );

    // Outputs straight from flip-flops
    assign prdata      = r_q.prdata;
    assign pready      = r_q.pready;
    assign pslverr     = r_q.pslverr;
    assign arb_request = lvl.req;
    assign arb_level   = lvl.level;

endmodule : ipf_prio_fields

// >>> tb/ipf_src_model.sv
// Purpose: Peripheral request lines facing the block
// Assumes: Sources are logic on pclk
// Notes:   A pattern shows one cycle after it is set
`timescale 1ns/100ps
module ipf_src_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [23:0] pattern,
    output logic      [23:0] src_request
);
    // Registered like real flags, so no same-edge race
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) src_request <= 24'h000000;
        else src_request <= pattern;
    end
endmodule : ipf_src_model

// >>> tb/ipf_prio_fields_props.sv
// Purpose: Port-level checks of the priority field block
// Assumes: One clock domain
// Notes:   Bound to every instance of the block
`timescale 1ns/100ps
module ipf_prio_props #(
    parameter int ADDR_W = 12,
    parameter int N_SRC  = 24
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               ce,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [N_SRC-1:0]   src_request,
    input wire logic [N_SRC-1:0]   arb_request,
    input wire logic [2*N_SRC-1:0] arb_level
);
    logic [N_SRC-1:0] lvl3;
    // A pair showing 11 would be a fourth level
    always_comb begin
        for (int k = 0; k < N_SRC; k++) lvl3[k] = &arb_level[2*k+:2];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    no_level3_a: assert property (lvl3 == '0)
        else $error("level three on arb_level");
    gated_req_a: assert property ($past(ce) |-> (arb_request & ~$past(src_request)) == '0)
        else $error("request without source");
    rsvd_src_a: assert property (!arb_request[13] && arb_level[27:26] == 2'h0)
        else $error("reserved source active");
    reset_clear_a: assert property (!$past(presetn) |-> arb_request == '0 && arb_level == '0)
        else $error("outputs not clear after reset");
    one_wait_a: assert property (psel && penable && !pready && ce |=> pready)
        else $error("no answer after one wait");
    ready_pulse_a: assert property (pready && ce |=> !pready)
        else $error("pready longer than one cycle");
    upper_zero_a: assert property (pready && paddr != 12'h080 |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    rsvd_read_a: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata[11:10] == 2'h0)
        else $error("reserved pair reads nonzero");
    err_place_a: assert property (pslverr |-> pready && !(paddr inside {12'h01C, 12'h020, 12'h024}))
        else $error("error on mapped word");
    freeze_hold_a: assert property (!ce |=> $stable(arb_request) && $stable(arb_level) && $stable(prdata))
        else $error("state moved while clock enable low");
endmodule : ipf_prio_props
bind ipf_prio_fields ipf_prio_props #(.ADDR_W(ADDR_W), .N_SRC(N_SRC)) u_ipf_prio_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_request(src_request), .arb_request(arb_request), .arb_level(arb_level));

// >>> tb/interrupt_priority_fields_tb.sv
// Purpose: Self-checking bench for the priority field block
// Assumes: APB answer waited for, never counted
// Notes:   Shadow registers give the arb_request and arb_level expectations
`timescale 1ns/100ps
module interrupt_priority_fields_tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic [23:0] s;} ipf_row_t;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] pattern, src_request, arb_request;
    logic [47:0] arb_level;
    logic [71:0] ex;
    logic [15:0] sh [3];
    int          fail_count, compares, cyc;
    ipf_row_t    rows [6];
    ipf_prio_fields u_ipf_prio_fields (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_request(src_request), .arb_request(arb_request),
        .arb_level(arb_level));
    ipf_src_model u_ipf_src_model (.pclk(pclk), .presetn(presetn), .pattern(pattern),
        .src_request(src_request));
    always #10 pclk = ~pclk;
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until the rising edge that samples pready high; only the hang guard ends a wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // level is field minus one, zero masks
    function automatic logic [71:0] exp_arb(input logic [23:0] s);
        logic [23:0] q;
        logic [47:0] l;
        logic [1:0]  f;
        q = '0;
        l = '0;
        for (int k = 0; k < 24; k++) begin
            f = sh[k/8][2*(k%8)+:2];
            if (f != 2'h0) begin
                q[k] = s[k];
                l[2*k+:2] = f - 2'h1;
            end
        end
        return {q, l};
    endfunction : exp_arb
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // Hang guard, far beyond the planned run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        rows[0] = '{12'h01C, 32'hFFFFFFFF, 32'h0000FFFF, 24'hFFFFFF};
        rows[1] = '{12'h020, 32'hFFFFFFFF, 32'h0000F3FF, 24'hFFFFFF};
        rows[2] = '{12'h024, 32'h0000E4E4, 32'h0000E4E4, 24'hA5A5A5};
        rows[3] = '{12'h01C, 32'h00001B1B, 32'h00001B1B, 24'h5A5A5A};
        rows[4] = '{12'h020, 32'hFFFF5A96, 32'h00005296, 24'hFFFFFF};
        rows[5] = '{12'h024, 32'h0000C00F, 32'h0000C00F, 24'hC3C3C3};
        pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; pattern = '0; sh = '{default: '0};
        fail_count = 0; compares = 0; cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Write, read back, then drive sources
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rd, er);
            apb(1'b0, rows[i].a, 32'h0, rd, er);
            sh[(rows[i].a - 12'h01C) >> 2] = rows[i].r[15:0];
            chk({er, rd}, {1'b0, rows[i].r});
            pattern <= rows[i].s;
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk({arb_request, arb_level}, exp_arb(rows[i].s));
        end
        // Unmapped word errs and reads zero
        apb(1'b0, 12'h040, 32'h0, rd, er);
        chk({er, rd}, {1'b1, 32'h0});
        // Reset in mid-run clears all fields
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        sh = '{default: '0};
        apb(1'b0, 12'h01C, 32'h0, rd, er);
        chk(rd, 32'h0);
        chk({arb_request, arb_level}, exp_arb(pattern));
        // Status word mirrors the gated requests
        apb(1'b1, 12'h020, 32'h0000_0003, rd, er);
        sh[1] = 16'h0003;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        ex = exp_arb(pattern);
        chk({arb_request, arb_level}, ex);
        apb(1'b0, 12'h080, 32'h0, rd, er);
        chk({er, rd}, {1'b0, 8'h00, ex[71:48]});
        // Clock enable low freezes the outputs
        ce <= 1'b0;
        pattern <= 24'h000000;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({arb_request, arb_level}, ex);
        @(posedge pclk);
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({arb_request, arb_level}, exp_arb(24'h000000));
        // Misaligned word errs and reads zero
        apb(1'b0, 12'h01E, 32'h0, rd, er);
        chk({er, rd}, {1'b1, 32'h0});
        finish_test();
    end
endmodule : interrupt_priority_fields_tb
